// *** core/sfc_defs.svh ***
// offsets, field positions, reset values and timing counts of the frame checker link
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH

`define SFC_CLK_NS            10
`define SFC_FRAME_BITS        32
`define SFC_CRC_INIT          5'h1f
`define SFC_CNT_BIT           21
`define SFC_CRC_LO            5

// device register map
`define SFC_ADDR_CTRL_BUCK    8'h00
`define SFC_ADDR_SECOND_BUCK  8'h01
`define SFC_ADDR_ERR_DETAIL   8'h1d
`define SFC_CTRL_BUCK_RST     16'h0008
`define SFC_CTRL_BUCK_WMASK   16'h067e
`define SFC_SECOND_BUCK_RST   16'h0008
`define SFC_SECOND_BUCK_WMASK 16'h063c

// error detail bits
`define SFC_ERR_CRC           0
`define SFC_ERR_LONG          1
`define SFC_ERR_SHORT         2
`define SFC_ERR_COUNT         3
`define SFC_ERR_SPI           4
`define SFC_ERR_TIMEOUT       5

// timing
`define SFC_SCLK_HALF_NS      500
`define SFC_SCLK_HALF_CYC     ((`SFC_SCLK_HALF_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_CSN_GAP_NS        6000
`define SFC_CSN_GAP_CYC       ((`SFC_CSN_GAP_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_CSN_FAIL_MS       20
`define SFC_CSN_FAIL_CYC      ((`SFC_CSN_FAIL_MS * 1000000 + `SFC_CLK_NS - 1) / `SFC_CLK_NS)

// host register map
`define SFC_H_CTRL            8'h00
`define SFC_H_CMD             8'h04
`define SFC_H_TXDATA          8'h08
`define SFC_H_RXFRAME         8'h0c
`define SFC_H_IRQ_STAT        8'h10
`define SFC_H_IRQ_CLR         8'h14
`define SFC_H_IRQ_EN          8'h18
`define SFC_EV_DONE           0
`define SFC_EV_CRC            1
`define SFC_EV_DEVERR         2

`endif

// *** core/sfc_pkg.sv ***
// types and the shared checksum function of the frame checker link
package sfc_pkg;

  typedef enum logic [2:0] {
    SFC_H_IDLE = 3'h0,
    SFC_H_LEAD = 3'h1,
    SFC_H_HIGH = 3'h2,
    SFC_H_LOW  = 3'h3,
    SFC_H_TAIL = 3'h4,
    SFC_H_GAP  = 3'h5
  } sfc_hstate_type;

  // serial generator x^5+x^2+1 over bits 31..22 then 20..5
  function automatic logic [4:0] sfc_crc(input logic [31:0] f);
    logic [4:0] c;
    logic       fb;
    c  = 5'h1f;
    fb = 1'b0;
    for (int i = 31; i >= 5; i--) begin
      if (i != 21) begin
        fb = c[4] ^ f[i];
        c  = {c[3], c[2], c[1] ^ fb, c[0], fb};
      end
    end
    return c;
  endfunction

endpackage

// *** core/sfc_if.sv ***
// serial link between the frame checker device and its controller
`timescale 1ns/10ps
`default_nettype none
interface sfc_if;
  logic sclk;
  logic chip_select_n;
  logic serial_in;
  logic serial_out_o;
  logic serial_out_oe;
  logic serial_out;

  // open drain with pull-up: low only while the device pulls it
  assign serial_out = (serial_out_oe && !serial_out_o) ? 1'b0 : 1'b1;

  modport dev (
    input  sclk,
    input  chip_select_n,
    input  serial_in,
    output serial_out_o,
    output serial_out_oe
  );

  modport host (
    output sclk,
    output chip_select_n,
    output serial_in,
    input  serial_out
  );
endinterface
`default_nettype wire

// *** core/sfc_device.sv ***
// device end: frame receive, checksum check, buck config registers, reply frame
// Operation
// - frames are 32 bits ending in 5-bit check
// - check uses LFSR x^5+x^2+1
// - inbound check skips counter bit 21
// - outbound check skips bit 21 too
// - generator preset to all ones per frame
// - bits enter from bit 31 downward
// - published test vector yields 00011
// - master keeps select high 6 us between frames
// - registers reset to defaults, reserved bits zero
// - controller buck fields at address 0x00
// - blanking time field bits 6:4, reset zero
// - second buck fields at address 0x01
// - bad frame discards write, replies error detail
// - master starts counter at 0, toggles each frame
// - inbound layout; sample falling, commit select rise
// - outbound bit 31 flags previous frame error
`timescale 1ns/10ps
`default_nettype none
`include "sfc_defs.svh"
module sfc_device #(
  parameter int CSN_FAIL_CYC = `SFC_CSN_FAIL_CYC
) (
  input  wire logic  clk_sys_i,
  input  wire logic  rstn_i,
  sfc_if.dev         link,
  input  wire logic  reset_state_i,
  input  wire logic  fault_state_i,
  output logic [15:0] ctrl_buck_cfg_o,
  output logic [15:0] second_buck_cfg_o,
  output logic       ctrl_buck_drive_current_max_o,
  output logic       ctrl_buck_monitor_threshold_o,
  output logic       ctrl_buck_spread_enable_o,
  output logic [2:0] ctrl_buck_blanking_time_o,
  output logic [1:0] ctrl_buck_softstart_select_o,
  output logic       second_buck_monitor_threshold_o,
  output logic       second_buck_spread_enable_o,
  output logic [1:0] second_buck_slew_rate_o,
  output logic [1:0] second_buck_softstart_select_o,
  output logic       frame_error_o
);

  // reply data for an address; unmapped addresses read zero
  function automatic logic [15:0] reg_read(input logic [7:0] a, input logic [15:0] r0,
                                           input logic [15:0] r1, input logic [15:0] e);
    case (a)
      `SFC_ADDR_CTRL_BUCK:   reg_read = r0;
      `SFC_ADDR_SECOND_BUCK: reg_read = r1;
      `SFC_ADDR_ERR_DETAIL:  reg_read = e;
      default:               reg_read = 16'h0000;
    endcase
  endfunction

  // synchronisers: first stage feeds only the second
  logic [1:0] sclk_s_r, csn_s_r, din_s_r, rst_s_r, flt_s_r;
  logic       sclk_d_r, csn_d_r;

  logic [31:0] rx_r, rx_nxt;
  logic [31:0] tx_r, tx_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic        tog_r, tog_nxt;
  logic [15:0] buck0_r, buck0_nxt;
  logic [15:0] buck1_r, buck1_nxt;
  logic [15:0] err_r, err_nxt;
  logic [31:0] tmo_r, tmo_nxt;
  logic        abort_r, abort_nxt;
  logic        oe_r, oe_nxt;
  logic        ferr_r, ferr_nxt;

  logic        sclk_fall, csn_fall, csn_rise;
  logic [15:0] ev;
  logic        any_err;
  logic [7:0]  rep_addr;
  logic [31:0] rep;

  assign sclk_fall = sclk_d_r & ~sclk_s_r[1];
  assign csn_fall  = csn_d_r & ~csn_s_r[1];
  assign csn_rise  = ~csn_d_r & csn_s_r[1];

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_s_r <= 2'h0;
      csn_s_r  <= 2'h3;
      din_s_r  <= 2'h0;
      rst_s_r  <= 2'h0;
      flt_s_r  <= 2'h0;
      sclk_d_r <= 1'b0;
      csn_d_r  <= 1'b1;
    end else begin
      sclk_s_r <= {sclk_s_r[0], link.sclk};
      csn_s_r  <= {csn_s_r[0], link.chip_select_n};
      din_s_r  <= {din_s_r[0], link.serial_in};
      rst_s_r  <= {rst_s_r[0], reset_state_i};
      flt_s_r  <= {flt_s_r[0], fault_state_i};
      sclk_d_r <= sclk_s_r[1];
      csn_d_r  <= csn_s_r[1];
    end
  end

  always_comb begin
    rx_nxt       = rx_r;
    tx_nxt       = tx_r;
    cnt_nxt      = cnt_r;
    tog_nxt      = tog_r;
    buck0_nxt    = buck0_r;
    buck1_nxt    = buck1_r;
    err_nxt      = err_r;
    tmo_nxt      = tmo_r;
    abort_nxt    = abort_r;
    ferr_nxt     = 1'b0;
    ev           = 16'h0000;
    rep_addr     = 8'h00;
    rep          = 32'h0000_0000;

    // select held low: count toward the low timeout
    if (!csn_s_r[1] && !abort_r) begin
      if (tmo_r == 32'(CSN_FAIL_CYC - 1)) begin
        abort_nxt = 1'b1;
      end else begin
        tmo_nxt = tmo_r + 32'h1;
      end
    end

    if (csn_fall) begin
      cnt_nxt   = 6'h00;
      tmo_nxt   = 32'h0;
      abort_nxt = 1'b0;
    end

    // sample on falling clock, then step the reply out
    if (sclk_fall && !csn_s_r[1] && !abort_r) begin
      rx_nxt = {rx_r[30:0], din_s_r[1]};
      tx_nxt = {tx_r[30:0], 1'b1};
      if (cnt_r != 6'h3f) begin
        cnt_nxt = cnt_r + 6'h01;
      end
    end

    if (csn_rise) begin
      ev[`SFC_ERR_SHORT]   = (cnt_r < 6'(`SFC_FRAME_BITS));
      ev[`SFC_ERR_LONG]    = (cnt_r > 6'(`SFC_FRAME_BITS));
      ev[`SFC_ERR_CRC]     = (sfc_pkg::sfc_crc(rx_r) != rx_r[4:0]);
      ev[`SFC_ERR_COUNT]   = (rx_r[`SFC_CNT_BIT] != tog_r);
      ev[`SFC_ERR_TIMEOUT] = abort_r;
      ev[`SFC_ERR_SPI]     = rx_r[31] && (rx_r[30:23] != `SFC_ADDR_CTRL_BUCK)
                             && (rx_r[30:23] != `SFC_ADDR_SECOND_BUCK);
      any_err = |ev;
      if (cnt_r == 6'(`SFC_FRAME_BITS)) begin
        tog_nxt = ~rx_r[`SFC_CNT_BIT];
      end
      // write commits at select rise only on a clean frame
      if (!any_err && rx_r[31]) begin
        if (rx_r[30:23] == `SFC_ADDR_CTRL_BUCK) begin
          buck0_nxt = (rx_r[20:5] & `SFC_CTRL_BUCK_WMASK) |
                      (buck0_r & ~`SFC_CTRL_BUCK_WMASK);
        end
        if (rx_r[30:23] == `SFC_ADDR_SECOND_BUCK) begin
          buck1_nxt = (rx_r[20:5] & `SFC_SECOND_BUCK_WMASK) |
                      (buck1_r & ~`SFC_SECOND_BUCK_WMASK);
        end
      end
      if (any_err) begin
        err_nxt  = ev;
        rep_addr = `SFC_ADDR_ERR_DETAIL;
      end else begin
        rep_addr = rx_r[30:23];
      end
      ferr_nxt     = any_err;
      rep = {any_err, rst_s_r[1], flt_s_r[1], rep_addr,
             reg_read(rep_addr, buck0_nxt, buck1_nxt, err_nxt), 5'h00};
      rep[4:0] = sfc_pkg::sfc_crc(rep);
      tx_nxt   = rep;
    end
    any_err = |ev;
  end

  // drive low only while selected and the current bit is zero
  always_comb begin
    oe_nxt = !csn_s_r[1] && !tx_r[31];
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_r       <= 32'h0000_0000;
      tx_r       <= 32'hffff_ffff;
      cnt_r      <= 6'h00;
      tog_r      <= 1'b0;
      buck0_r    <= `SFC_CTRL_BUCK_RST;
      buck1_r    <= `SFC_SECOND_BUCK_RST;
      err_r      <= 16'h0000;
      tmo_r      <= 32'h0;
      abort_r    <= 1'b0;
      oe_r       <= 1'b0;
      ferr_r     <= 1'b0;
    end else begin
      rx_r       <= rx_nxt;
      tx_r       <= tx_nxt;
      cnt_r      <= cnt_nxt;
      tog_r      <= tog_nxt;
      buck0_r    <= buck0_nxt;
      buck1_r    <= buck1_nxt;
      err_r      <= err_nxt;
      tmo_r      <= tmo_nxt;
      abort_r    <= abort_nxt;
      oe_r       <= oe_nxt;
      ferr_r     <= ferr_nxt;
    end
  end

  assign link.serial_out_o  = 1'b0;
  assign link.serial_out_oe = oe_r;

  assign ctrl_buck_cfg_o                 = buck0_r;
  assign second_buck_cfg_o               = buck1_r;
  assign ctrl_buck_drive_current_max_o   = buck0_r[1];
  assign ctrl_buck_monitor_threshold_o   = buck0_r[2];
  assign ctrl_buck_spread_enable_o       = buck0_r[3];
  assign ctrl_buck_blanking_time_o       = buck0_r[6:4];
  assign ctrl_buck_softstart_select_o    = buck0_r[10:9];
  assign second_buck_monitor_threshold_o = buck1_r[2];
  assign second_buck_spread_enable_o     = buck1_r[3];
  assign second_buck_slew_rate_o         = buck1_r[5:4];
  assign second_buck_softstart_select_o  = buck1_r[10:9];
  assign frame_error_o                   = ferr_r;

endmodule
`default_nettype wire

// *** core/sfc_host.sv ***
// controller end: builds frames, drives the serial clock, checks replies
`timescale 1ns/10ps
`default_nettype none
`include "sfc_defs.svh"
module sfc_host (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  sfc_if.host              link,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             irq_o
);

  sfc_pkg::sfc_hstate_type st_r, st_nxt;
  logic [9:0]  div_r, div_nxt;
  logic [5:0]  bit_r, bit_nxt;
  logic [31:0] tx_r, tx_nxt;
  logic [31:0] rx_r, rx_nxt;
  logic        sclk_r, sclk_nxt;
  logic        csn_r, csn_nxt;
  logic        mosi_r, mosi_nxt;
  logic        tog_r, tog_nxt;
  logic [9:0]  cmd_r, cmd_nxt;
  logic [15:0] txd_r, txd_nxt;
  logic [2:0]  ist_r, ist_nxt;
  logic [2:0]  ien_r, ien_nxt;
  logic        irq_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0]  miso_s_r;
  logic [2:0]  ev;
  logic        tick;
  logic [31:0] f;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      miso_s_r <= 2'h3;
    end else begin
      miso_s_r <= {miso_s_r[0], link.serial_out};
    end
  end

  always_comb begin
    st_nxt   = st_r;
    div_nxt  = div_r + 10'h001;
    bit_nxt  = bit_r;
    tx_nxt   = tx_r;
    rx_nxt   = rx_r;
    sclk_nxt = sclk_r;
    csn_nxt  = csn_r;
    mosi_nxt = mosi_r;
    tog_nxt  = tog_r;
    cmd_nxt  = cmd_r;
    txd_nxt  = txd_r;
    ien_nxt  = ien_r;
    ev       = 3'h0;
    f        = 32'h0000_0000;
    tick     = (st_r == sfc_pkg::SFC_H_GAP) ? (div_r == 10'(`SFC_CSN_GAP_CYC - 1))
                                            : (div_r == 10'(`SFC_SCLK_HALF_CYC - 1));
    if (tick) begin
      div_nxt = 10'h000;
    end

    case (st_r)
      sfc_pkg::SFC_H_IDLE: begin
        div_nxt = 10'h000;
        if (wr_i && addr_i == `SFC_H_CTRL && wdata_i[0]) begin
          // first frame after reset carries counter 0, then alternates
          f = {cmd_r[8], cmd_r[7:0], cmd_r[9], tog_r, txd_r, 5'h00};
          f[4:0]   = sfc_pkg::sfc_crc(f);
          tx_nxt   = f;
          csn_nxt  = 1'b0;
          mosi_nxt = f[31];
          bit_nxt  = 6'h00;
          st_nxt   = sfc_pkg::SFC_H_LEAD;
        end
      end
      sfc_pkg::SFC_H_LEAD: begin
        if (tick) begin
          sclk_nxt = 1'b1;
          st_nxt   = sfc_pkg::SFC_H_HIGH;
        end
      end
      sfc_pkg::SFC_H_HIGH: begin
        if (tick) begin
          sclk_nxt = 1'b0;
          rx_nxt   = {rx_r[30:0], miso_s_r[1]};
          tx_nxt   = {tx_r[30:0], 1'b0};
          bit_nxt  = bit_r + 6'h01;
          st_nxt   = sfc_pkg::SFC_H_LOW;
        end
      end
      sfc_pkg::SFC_H_LOW: begin
        if (tick) begin
          sclk_nxt = 1'b1;
          if (bit_r == 6'(`SFC_FRAME_BITS)) begin
            st_nxt = sfc_pkg::SFC_H_TAIL;
          end else begin
            mosi_nxt = tx_r[31];
            st_nxt   = sfc_pkg::SFC_H_HIGH;
          end
        end
      end
      sfc_pkg::SFC_H_TAIL: begin
        if (tick) begin
          csn_nxt = 1'b1;
          tog_nxt = ~tog_r;
          ev[`SFC_EV_DONE]   = 1'b1;
          ev[`SFC_EV_CRC]    = (sfc_pkg::sfc_crc(rx_r) != rx_r[4:0]);
          ev[`SFC_EV_DEVERR] = rx_r[31];
          st_nxt  = sfc_pkg::SFC_H_GAP;
        end
      end
      sfc_pkg::SFC_H_GAP: begin
        // select stays high long enough for the device to take the command
        if (tick) begin
          // back to idle low so every frame opens with select low before a rising clock
          sclk_nxt = 1'b0;
          st_nxt   = sfc_pkg::SFC_H_IDLE;
        end
      end
      default: begin
        st_nxt  = sfc_pkg::SFC_H_IDLE;
        csn_nxt = 1'b1;
      end
    endcase

    if (wr_i) begin
      case (addr_i)
        `SFC_H_CMD:    cmd_nxt = wdata_i[9:0];
        `SFC_H_TXDATA: txd_nxt = wdata_i[15:0];
        `SFC_H_IRQ_EN: ien_nxt = wdata_i[2:0];
        default:       ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    ist_nxt = ist_r;
    if (wr_i && addr_i == `SFC_H_IRQ_CLR) begin
      ist_nxt = ist_r & ~wdata_i[2:0];
    end
    ist_nxt = ist_nxt | ev;
    irq_nxt = |(ist_nxt & ien_nxt);

    rdata_nxt = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        `SFC_H_CTRL:     rdata_nxt = {30'h0, tog_r, st_r != sfc_pkg::SFC_H_IDLE};
        `SFC_H_CMD:      rdata_nxt = {22'h0, cmd_r};
        `SFC_H_TXDATA:   rdata_nxt = {16'h0, txd_r};
        `SFC_H_RXFRAME:  rdata_nxt = rx_r;
        `SFC_H_IRQ_STAT: rdata_nxt = {29'h0, ist_r};
        `SFC_H_IRQ_EN:   rdata_nxt = {29'h0, ien_r};
        default:         rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r    <= sfc_pkg::SFC_H_IDLE;
      div_r   <= 10'h000;
      bit_r   <= 6'h00;
      tx_r    <= 32'h0000_0000;
      rx_r    <= 32'h0000_0000;
      sclk_r  <= 1'b0;
      csn_r   <= 1'b1;
      mosi_r  <= 1'b0;
      tog_r   <= 1'b0;
      cmd_r   <= 10'h000;
      txd_r   <= 16'h0000;
      ist_r   <= 3'h0;
      ien_r   <= 3'h0;
      irq_o   <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end else begin
      st_r    <= st_nxt;
      div_r   <= div_nxt;
      bit_r   <= bit_nxt;
      tx_r    <= tx_nxt;
      rx_r    <= rx_nxt;
      sclk_r  <= sclk_nxt;
      csn_r   <= csn_nxt;
      mosi_r  <= mosi_nxt;
      tog_r   <= tog_nxt;
      cmd_r   <= cmd_nxt;
      txd_r   <= txd_nxt;
      ist_r   <= ist_nxt;
      ien_r   <= ien_nxt;
      irq_o   <= irq_nxt;
      rdata_o <= rdata_nxt;
    end
  end

  assign link.sclk          = sclk_r;
  assign link.chip_select_n = csn_r;
  assign link.serial_in     = mosi_r;

endmodule
`default_nettype wire

// *** tb/sfc_assertions.sv ***
// link checker: frame length, both checksums, counter bit and serial timing
`timescale 1ns/10ps
`default_nettype none
module sfc_assertions (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic serial_out
);
  logic        sclk_q, csn_q, cnt_e, seen, fall, rise;
  logic [15:0] sc_n, cs_n;
  logic [5:0]  nf;
  logic [31:0] fi, fo;
  logic [4:0]  ci, co;

  function automatic logic [4:0] step(input logic [4:0] c, input logic b);
    return {c[3], c[2], c[1] ^ c[4] ^ b, c[0], c[4] ^ b};
  endfunction

  assign fall = sclk_q && !sclk && !chip_select_n;
  assign rise = !csn_q && chip_select_n;

  // level counters saturate so a long idle spell never wraps into a short one
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
      sc_n   <= 16'hffff;
      cs_n   <= 16'hffff;
      cnt_e  <= 1'b0;
      seen   <= 1'b0;
      nf     <= 6'h0;
      ci     <= 5'h1f;
      co     <= 5'h1f;
    end else begin
      sclk_q <= sclk;
      csn_q  <= chip_select_n;
      sc_n   <= (sclk != sclk_q) ? 16'h1 : sc_n + {15'h0, sc_n != 16'hffff};
      cs_n   <= (chip_select_n != csn_q) ? 16'h1 : cs_n + {15'h0, cs_n != 16'hffff};
      if (csn_q && !chip_select_n) begin
        nf <= 6'h0;
        ci <= 5'h1f;
        co <= 5'h1f;
      end else if (fall) begin
        nf <= nf + 6'h1;
        fi <= {fi[30:0], serial_in};
        fo <= {fo[30:0], serial_out};
        // fall number 10 carries the counter bit, kept out of both sums
        if (nf < 6'd27 && nf != 6'd10) begin
          ci <= step(ci, serial_in);
          co <= step(co, serial_out);
        end
      end
      if (rise) begin
        cnt_e <= cnt_e ^ (nf == 6'd32);
        seen  <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  chk_frame_len: assert property (rise |-> nf == 6'd32)
    else $error("frame length wrong");
  chk_crc_in: assert property (rise |-> fi[4:0] == ci)
    else $error("outgoing check field wrong");
  chk_crc_out: assert property (rise && seen |-> fo[4:0] == co)
    else $error("reply check field wrong");
  chk_cnt_toggle: assert property (rise |-> fi[21] == cnt_e)
    else $error("counter bit out of step");
  chk_csn_setup: assert property ($rose(sclk) && !chip_select_n |-> cs_n >= 16'd50)
    else $error("select to clock setup short");
  chk_clk_setup: assert property (rise |-> sclk && sc_n >= 16'd50)
    else $error("clock to select setup short");
  chk_csn_gap: assert property ($fell(chip_select_n) |-> cs_n >= 16'd600)
    else $error("select high gap short");
  chk_clk_high: assert property ($fell(sclk) |-> sc_n >= 16'd40)
    else $error("clock high time short");
  chk_clk_low: assert property ($rose(sclk) |-> sc_n >= 16'd40)
    else $error("clock low time short");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// bench: host and device ends joined over the link, driven through host registers
`timescale 1ns/10ps
`default_nettype none
`include "sfc_defs.svh"
module tb;
  localparam logic [31:0] HDR = 32'hffffffe0;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        rs_st     = 1'b0;
  logic        fl_st     = 1'b0;
  logic        rd_q      = 1'b0;
  logic        sclk_q    = 1'b0;
  logic        csn_q     = 1'b1;
  logic        cnt_e     = 1'b0;
  logic [7:0]  addr_i    = 8'h0;
  logic [31:0] wdata_i   = 32'h0;
  logic [15:0] e0        = `SFC_CTRL_BUCK_RST;
  logic [15:0] e1        = `SFC_SECOND_BUCK_RST;
  logic [31:0] rdata_o, fr;
  logic        irq_o, f_err, cm0, th0, sp0, th1, sp1;
  logic [2:0]  blk;
  logic [1:0]  ss0, sr1, ss1;
  logic [15:0] c0, c1, d;
  logic [31:0] eq[$], mq[$], wq[$], wm[$];
  int          error_cnt = 0;
  int          checked   = 0;
  int          cyc       = 0;
  int          fe_cnt    = 0;

  sfc_if lnk ();
  sfc_host i_sfc_host (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(lnk), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
  // short stuck-select limit keeps a hung frame from stalling the run
  sfc_device #(.CSN_FAIL_CYC(5000)) i_sfc_device (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .link(lnk), .reset_state_i(rs_st), .fault_state_i(fl_st), .ctrl_buck_cfg_o(c0),
    .second_buck_cfg_o(c1), .ctrl_buck_drive_current_max_o(cm0),
    .ctrl_buck_monitor_threshold_o(th0), .ctrl_buck_spread_enable_o(sp0),
    .ctrl_buck_blanking_time_o(blk), .ctrl_buck_softstart_select_o(ss0),
    .second_buck_monitor_threshold_o(th1), .second_buck_spread_enable_o(sp1),
    .second_buck_slew_rate_o(sr1), .second_buck_softstart_select_o(ss1),
    .frame_error_o(f_err));
  sfc_assertions i_sfc_assertions (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .sclk(lnk.sclk), .chip_select_n(lnk.chip_select_n), .serial_in(lnk.serial_in),
    .serial_out(lnk.serial_out));

  initial forever #5 clk_sys_i = ~clk_sys_i;

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk_sys_i);
    wr_i    <= w;
    rd_i    <= !w;
    addr_i  <= a;
    wdata_i <= dt;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic launch(input logic w, input logic [7:0] a, input logic [15:0] dt,
                        input logic [31:0] m);
    wq.push_back({w, a, 1'b0, cnt_e, dt, 5'h03});
    wm.push_back(m);
    cnt_e = !cnt_e;
    bus(1'b1, `SFC_H_CMD, {22'h0, 1'b0, w, a});
    bus(1'b1, `SFC_H_TXDATA, {16'h0, dt});
    bus(1'b1, `SFC_H_CTRL, 32'h1);
  endtask

  task automatic frame(input logic w, input logic [7:0] a, input logic [15:0] dt,
                       input logic [31:0] m);
    int n;
    n = 0;
    launch(w, a, dt, m);
    while (irq_o !== 1'b1 && n < 5000) begin
      @(posedge clk_sys_i);
      n++;
    end
    cmp({31'h0, irq_o}, 32'h1, "frame done");
    bus(1'b1, `SFC_H_IRQ_CLR, 32'h7);
    // lets the select-high gap run out so the next start is not ignored
    repeat (700) @(posedge clk_sys_i);
  endtask

  task automatic chk_cfg();
    cmp({c0, c1}, {e0, e1}, "cfg");
    cmp(32'({ss0, blk, sp0, th0, cm0}), 32'({e0[10:9], e0[6:1]}), "ctrl fields");
    cmp(32'({ss1, sr1, sp1, th1}), 32'({e1[10:9], e1[5:2]}), "second fields");
  endtask

  always @(posedge clk_sys_i) begin
    if (rd_q) begin
      cmp(rdata_o & mq[0], eq[0] & mq[0], "read");
      eq.delete(0);
      mq.delete(0);
    end
    if (f_err === 1'b1) fe_cnt++;
    if (sclk_q && !lnk.sclk && !lnk.chip_select_n) fr <= {fr[30:0], lnk.serial_in};
    if (!csn_q && lnk.chip_select_n && wq.size() > 0) begin
      cmp(fr & wm[0], wq[0] & wm[0], "wire frame");
      wq.delete(0);
      wm.delete(0);
    end
    rd_q   <= rd_i;
    sclk_q <= lnk.sclk;
    csn_q  <= lnk.chip_select_n;
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      $display("[FAIL] %0t run did not finish", $time);
      close_out();
    end
  end

  initial begin
    void'($urandom(32'h8a6c22cf));
    @(posedge clk_sys_i);
    rs_st <= 1'($urandom);
    fl_st <= 1'($urandom);
    repeat (16) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk_cfg();
    rd(`SFC_H_IRQ_STAT, 32'h0, 32'h7);
    bus(1'b1, 8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h0, 32'hffffffff);
    bus(1'b1, `SFC_H_IRQ_EN, 32'h1);
    rd(`SFC_H_IRQ_EN, 32'h1, 32'h7);
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0 : 16'($urandom);
      frame(1'b1, `SFC_ADDR_CTRL_BUCK, d, HDR);
      e0 = d & `SFC_CTRL_BUCK_WMASK;
      d = (i == 2) ? 16'($urandom) : ~d;
      frame(1'b1, `SFC_ADDR_SECOND_BUCK, d, HDR);
      e1 = d & `SFC_SECOND_BUCK_WMASK;
      chk_cfg();
    end
    frame(1'b0, `SFC_ADDR_CTRL_BUCK, 16'h0, HDR);
    frame(1'b0, `SFC_ADDR_SECOND_BUCK, 16'h0, HDR);
    rd(`SFC_H_RXFRAME, {1'b0, rs_st, fl_st, 8'h00, e0, 5'h0}, HDR);
    // the published vector is also a write to an unwritable place, so it is the error case
    frame(1'b1, 8'h05, 16'hffff, 32'hffffffff);
    chk_cfg();
    cmp(32'(fe_cnt), 32'h1, "error pulse");
    bus(1'b1, `SFC_H_IRQ_EN, 32'h0);
    launch(1'b0, `SFC_ADDR_SECOND_BUCK, 16'h0, HDR);
    repeat (4000) @(posedge clk_sys_i);
    cmp({31'h0, irq_o}, 32'h0, "masked irq");
    rd(`SFC_H_IRQ_STAT, 32'h5, 32'h7);
    rd(`SFC_H_RXFRAME, {1'b1, rs_st, fl_st, `SFC_ADDR_ERR_DETAIL, 16'h0010, 5'h0}, HDR);
    bus(1'b1, `SFC_H_IRQ_EN, 32'h7);
    repeat (3) @(posedge clk_sys_i);
    cmp({31'h0, irq_o}, 32'h1, "irq raised");
    bus(1'b1, `SFC_H_IRQ_CLR, 32'h7);
    repeat (3) @(posedge clk_sys_i);
    cmp({31'h0, irq_o}, 32'h0, "irq cleared");
    bus(1'b1, `SFC_H_IRQ_EN, 32'h1);
    frame(1'b0, `SFC_ADDR_CTRL_BUCK, 16'h0, HDR);
    rd(`SFC_H_RXFRAME, {1'b0, rs_st, fl_st, 8'h01, e1, 5'h0}, HDR);
    repeat (5) @(posedge clk_sys_i);
    close_out();
  end
endmodule
`default_nettype wire
